// ### hdl/ixu_pkg.sv
// package: opcodes, state encodings and data carriers for the index unit
package ixu_pkg;
    localparam int unsigned IXU_W = 16;
    localparam logic [15:0] IXU_ADDR_ACC_A = 16'h0000;
    localparam logic [15:0] IXU_ADDR_ACC_B = 16'h0001;
    localparam logic [15:0] IXU_RST_WORD = 16'h0000;
    localparam logic [15:0] IXU_PC_STEP2 = 16'h0002;
    localparam logic [15:0] IXU_ADDR_MASK = 16'h7fff;
    localparam int unsigned IXU_IND_BIT = 15;

    typedef enum logic [4:0] {
        IXU_OP_NONE = 5'h00,
        IXU_OP_LDA_X = 5'h01, IXU_OP_LDA_Y = 5'h02,
        IXU_OP_LDB_X = 5'h03, IXU_OP_LDB_Y = 5'h04,
        IXU_OP_STA_X = 5'h05, IXU_OP_STA_Y = 5'h06,
        IXU_OP_STB_X = 5'h07, IXU_OP_STB_Y = 5'h08,
        IXU_OP_LD_X = 5'h09, IXU_OP_LD_Y = 5'h0a,
        IXU_OP_ST_X = 5'h0b, IXU_OP_ST_Y = 5'h0c,
        IXU_OP_SWP_AX = 5'h0d, IXU_OP_SWP_AY = 5'h0e,
        IXU_OP_SWP_BX = 5'h0f, IXU_OP_SWP_BY = 5'h10,
        IXU_OP_JSA = 5'h11, IXU_OP_JSB = 5'h12,
        IXU_OP_JSY = 5'h13, IXU_OP_JPY = 5'h14
    } ixu_op_t;

    typedef enum logic [2:0] {
        IXU_ST_IDLE = 3'b000,
        IXU_ST_IND = 3'b100,
        IXU_ST_EXEC = 3'b001,
        IXU_ST_MEM = 3'b011,
        IXU_ST_DONE = 3'b010
    } ixu_state_t;

    typedef struct packed {
        ixu_op_t     op;
        logic [15:0] opnd;
        logic        ind;
        logic        code_data_separation_mode;
        logic [15:0] base;
    } ixu_req_t;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic        chk;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ixu_mem_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] p;
        logic [15:0] m;
    } ixu_regs_t;
endpackage

// ### hdl/ixu_exec.sv
// index register group execution unit with its register set
// Overview of operation
// - a load to A reads at operand address plus X or Y
// - a load to B reads at operand address plus X or Y
// - indexed access leaves address in M, index and source unchanged
// - indirection resolves before indexing; effective address drops bit 15
// - in separation mode the base register is added before the index
// - index is a signed value, so addresses may fall below operand
// - loading X or Y reads memory; addresses 0 and 1 give A and B
// - store of A writes A at operand plus index, A unchanged
// - store of B writes B at operand plus index, B unchanged
// - store of X or Y; addresses 0 and 1 write into A and B
// - four swaps exchange A or B with X or Y in one step
// - jump-save-A branches to second word, A gets P plus two
// - jump-save-B branches to second word, B gets P plus two
// - indirect chains through 0 and 1 read accumulators A and B
// - jump-save-Y branches to possibly indirect address, Y gets P+2
// - indexed jump loads P with operand plus Y, no indirection
// - indexed jump makes no memory reference, so no protection check is raised for it
`timescale 1ns/1ps
module ixu_exec
    import ixu_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    input  wire logic        req_valid_i,
    input  wire ixu_req_t    req_i,
    output logic             req_ready_o,
    output logic             done_o,
    output ixu_mem_t         mem_o,
    input  wire logic        mem_ack_i,
    input  wire logic [15:0] mem_rdata_i,
    input  wire logic        ld_valid_i,
    input  wire ixu_regs_t   ld_regs_i,
    output ixu_regs_t        regs_o
);
    ixu_state_t  state_ff, nxt_state;
    ixu_req_t    cur_ff;
    ixu_regs_t   regs_ff;
    logic [15:0] ptr_ff;
    logic        mreq_ff, mwr_ff, mchk_ff;
    logic [15:0] maddr_ff, mwdata_ff;
    logic        done_ff;

    function automatic logic is_acc(input logic [15:0] ad);
        return (ad == IXU_ADDR_ACC_A) || (ad == IXU_ADDR_ACC_B);
    endfunction

    // wraps at 16 bits, then the indirect bit is dropped
    function automatic logic [15:0] ea_of(input logic [15:0] ad,
                                          input logic [15:0] ix);
        logic [15:0] s;
        s = ad + ix;
        return s & IXU_ADDR_MASK;
    endfunction

    function automatic logic [15:0] acc_rd(input logic [15:0] ad,
                                           input ixu_regs_t r);
        return (ad == IXU_ADDR_ACC_A) ? r.a : r.b;
    endfunction

    function automatic logic uses_y(input ixu_op_t o);
        return o inside {IXU_OP_LDA_Y, IXU_OP_LDB_Y, IXU_OP_STA_Y,
                         IXU_OP_STB_Y, IXU_OP_JPY};
    endfunction

    function automatic logic is_idx(input ixu_op_t o);
        return o inside {IXU_OP_LDA_X, IXU_OP_LDA_Y, IXU_OP_LDB_X,
                         IXU_OP_LDB_Y, IXU_OP_STA_X, IXU_OP_STA_Y,
                         IXU_OP_STB_X, IXU_OP_STB_Y, IXU_OP_JPY};
    endfunction

    function automatic logic is_st(input ixu_op_t o);
        return o inside {IXU_OP_STA_X, IXU_OP_STA_Y, IXU_OP_STB_X,
                         IXU_OP_STB_Y, IXU_OP_ST_X, IXU_OP_ST_Y};
    endfunction

    function automatic logic is_mem(input ixu_op_t o);
        return o inside {IXU_OP_LDA_X, IXU_OP_LDA_Y, IXU_OP_LDB_X,
                         IXU_OP_LDB_Y, IXU_OP_LD_X, IXU_OP_LD_Y}
               || is_st(o);
    endfunction

    logic [15:0] idx_v, ea_v, wsrc_v;
    always_comb begin
        idx_v = uses_y(cur_ff.op) ? regs_ff.y : regs_ff.x;
        ea_v = is_idx(cur_ff.op) ? ea_of(ptr_ff, idx_v)
                                 : (ptr_ff & IXU_ADDR_MASK);
        unique case (cur_ff.op)
            IXU_OP_STA_X, IXU_OP_STA_Y: wsrc_v = regs_ff.a;
            IXU_OP_STB_X, IXU_OP_STB_Y: wsrc_v = regs_ff.b;
            IXU_OP_ST_X:                wsrc_v = regs_ff.x;
            IXU_OP_ST_Y:                wsrc_v = regs_ff.y;
            default:                    wsrc_v = IXU_RST_WORD;
        endcase
    end

    logic        take, ind_now, chase_ok;
    logic [15:0] first_ptr;
    always_comb begin
        take = req_valid_i && (state_ff == IXU_ST_IDLE);
        // separation mode: base added before the index
        first_ptr = req_i.code_data_separation_mode ? req_i.opnd + req_i.base
                              : req_i.opnd;
        // indexed jump never chases an indirect chain
        chase_ok = (req_i.op != IXU_OP_JPY);
        ind_now = take && req_i.ind && chase_ok;
    end

    // word fetched during indirection: accumulators answer 0 and 1
    logic [15:0] ind_word;
    logic        ind_acc;
    always_comb begin
        ind_acc = is_acc(ptr_ff & IXU_ADDR_MASK);
        ind_word = ind_acc ? acc_rd(ptr_ff & IXU_ADDR_MASK, regs_ff)
                           : mem_rdata_i;
    end

    logic        acc_ea, mem_op, exec_fin;
    always_comb begin
        acc_ea = is_acc(ea_v);
        mem_op = is_mem(cur_ff.op);
        // 0 and 1 never leave the unit, so no memory cycle for them
        exec_fin = !(mem_op && !acc_ea);
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            IXU_ST_IDLE:
                if (take) begin
                    nxt_state = ind_now ? IXU_ST_IND : IXU_ST_EXEC;
                end
            IXU_ST_IND:
                // a level through 0 or 1 costs one cycle, memory an ack
                if (ind_acc || mem_ack_i) begin
                    if (!ind_word[IXU_IND_BIT]) begin
                        nxt_state = IXU_ST_EXEC;
                    end
                end
            IXU_ST_EXEC:
                nxt_state = exec_fin ? IXU_ST_DONE : IXU_ST_MEM;
            IXU_ST_MEM:
                if (mem_ack_i) begin
                    nxt_state = IXU_ST_DONE;
                end
            IXU_ST_DONE:
                nxt_state = IXU_ST_IDLE;
            default:
                nxt_state = IXU_ST_IDLE;
        endcase
    end

    // reset wins over the enable, so a frozen unit can still be cleared
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_ff <= IXU_ST_IDLE;
        end else if (ce_i) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cur_ff <= '0;
            ptr_ff <= IXU_RST_WORD;
        end else if (ce_i) begin
            if (take) begin
                // whole request latched; the core may move on once taken
                cur_ff <= req_i;
                ptr_ff <= first_ptr;
            end else if (state_ff == IXU_ST_IND &&
                         (ind_acc || mem_ack_i)) begin
                ptr_ff <= ind_word;
            end
        end
    end

    logic mem_start, ind_first, ind_step, ind_more;
    always_comb begin
        mem_start = (state_ff == IXU_ST_EXEC) && !exec_fin;
        // first indirect level goes out unless it names 0 or 1
        ind_first = ind_now && !is_acc(first_ptr & IXU_ADDR_MASK);
        ind_step = (state_ff == IXU_ST_IND) && (ind_acc || mem_ack_i);
        // chain runs on to memory only for a flagged word above 1
        ind_more = ind_word[IXU_IND_BIT] &&
                   !is_acc(ind_word & IXU_ADDR_MASK);
    end

    // request strobe; protection flag is set on every request, since 0 and 1 never go out
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mreq_ff <= 1'b0;
            mwr_ff <= 1'b0;
            mchk_ff <= 1'b0;
        end else if (ce_i) begin
            if (ind_first) begin
                mreq_ff <= 1'b1;
                mwr_ff <= 1'b0;
                mchk_ff <= 1'b1;
            end else if (ind_step) begin
                mreq_ff <= ind_more;
                mwr_ff <= 1'b0;
                mchk_ff <= 1'b1;
            end else if (mem_start) begin
                mreq_ff <= 1'b1;
                mwr_ff <= is_st(cur_ff.op);
                mchk_ff <= !acc_ea;
            end else if (mem_ack_i) begin
                mreq_ff <= 1'b0;
            end
        end
    end

    // address moves at each indirect level and at launch; data only moves at launch
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            maddr_ff <= IXU_RST_WORD;
            mwdata_ff <= IXU_RST_WORD;
        end else if (ce_i) begin
            if (ind_first) begin
                maddr_ff <= first_ptr & IXU_ADDR_MASK;
            end else if (ind_step) begin
                maddr_ff <= ind_word & IXU_ADDR_MASK;
            end else if (mem_start) begin
                maddr_ff <= ea_v;
                mwdata_ff <= wsrc_v;
            end
        end
    end

    // register file: all writes, copies into X/Y included, go through this block
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            regs_ff <= '0;
        end else if (ce_i) begin
            if (ld_valid_i && state_ff == IXU_ST_IDLE) begin
                regs_ff <= ld_regs_i;
            end else if (state_ff == IXU_ST_EXEC) begin
                // M and the target change; swaps trade both registers, other ops keep index and sources
                regs_ff.m <= ea_v;
                unique case (cur_ff.op)
                    IXU_OP_SWP_AX: begin
                        regs_ff.a <= regs_ff.x;
                        regs_ff.x <= regs_ff.a;
                    end
                    IXU_OP_SWP_AY: begin
                        regs_ff.a <= regs_ff.y;
                        regs_ff.y <= regs_ff.a;
                    end
                    IXU_OP_SWP_BX: begin
                        regs_ff.b <= regs_ff.x;
                        regs_ff.x <= regs_ff.b;
                    end
                    IXU_OP_SWP_BY: begin
                        regs_ff.b <= regs_ff.y;
                        regs_ff.y <= regs_ff.b;
                    end
                    IXU_OP_JSA: begin
                        regs_ff.a <= regs_ff.p + IXU_PC_STEP2;
                        regs_ff.p <= ea_v;
                    end
                    IXU_OP_JSB: begin
                        regs_ff.b <= regs_ff.p + IXU_PC_STEP2;
                        regs_ff.p <= ea_v;
                    end
                    IXU_OP_JSY: begin
                        regs_ff.y <= regs_ff.p + IXU_PC_STEP2;
                        regs_ff.p <= ea_v;
                    end
                    IXU_OP_JPY: begin
                        regs_ff.p <= ea_v;
                    end
                    IXU_OP_LD_X, IXU_OP_LD_Y,
                    IXU_OP_LDA_X, IXU_OP_LDA_Y,
                    IXU_OP_LDB_X, IXU_OP_LDB_Y: begin
                        if (acc_ea) begin
                            // 0 and 1 read the accumulators
                            unique case (cur_ff.op)
                                IXU_OP_LD_X: regs_ff.x <=
                                    acc_rd(ea_v, regs_ff);
                                IXU_OP_LD_Y: regs_ff.y <=
                                    acc_rd(ea_v, regs_ff);
                                IXU_OP_LDA_X, IXU_OP_LDA_Y: regs_ff.a <=
                                    acc_rd(ea_v, regs_ff);
                                default: regs_ff.b <=
                                    acc_rd(ea_v, regs_ff);
                            endcase
                        end
                    end
                    IXU_OP_ST_X, IXU_OP_ST_Y,
                    IXU_OP_STA_X, IXU_OP_STA_Y,
                    IXU_OP_STB_X, IXU_OP_STB_Y: begin
                        if (ea_v == IXU_ADDR_ACC_A) begin
                            regs_ff.a <= wsrc_v;
                        end else if (ea_v == IXU_ADDR_ACC_B) begin
                            regs_ff.b <= wsrc_v;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (state_ff == IXU_ST_MEM && mem_ack_i &&
                         !mwr_ff) begin
                unique case (cur_ff.op)
                    IXU_OP_LDA_X, IXU_OP_LDA_Y:
                        regs_ff.a <= mem_rdata_i;
                    IXU_OP_LDB_X, IXU_OP_LDB_Y:
                        regs_ff.b <= mem_rdata_i;
                    IXU_OP_LD_X: regs_ff.x <= mem_rdata_i;
                    IXU_OP_LD_Y: regs_ff.y <= mem_rdata_i;
                    default: begin
                    end
                endcase
            end
        end
    end

    // registered so the pulse lines up with the last register write
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            done_ff <= 1'b0;
        end else if (ce_i) begin
            done_ff <= (nxt_state == IXU_ST_DONE) &&
                       (state_ff != IXU_ST_DONE);
        end
    end

    always_comb begin
        // combinational so a new request can follow done at once
        req_ready_o = (state_ff == IXU_ST_IDLE);
        done_o = done_ff;
        mem_o = '{req: mreq_ff, wr: mwr_ff, chk: mchk_ff,
                  addr: maddr_ff, wdata: mwdata_ff};
        regs_o = regs_ff;
    end
endmodule // ixu_exec

// ### dv/ixu_mem_model.sv
// memory model that ignores the protection flag, answering after a set wait
`timescale 1ns/1ps
module ixu_mem_model
    import ixu_pkg::*;
(
    input  wire logic       clk_i,
    input  wire ixu_mem_t   mem_i,
    input  wire logic [3:0] lat_i,
    output logic            ack_o,
    output logic [15:0]     rdata_o
);
    logic [15:0] mem [0:32767];
    logic [3:0]  cnt;
    // words never carry bit 15, so no chain runs on by accident
    initial begin
        ack_o = 1'b0;
        rdata_o = 16'h0000;
        cnt = 4'h0;
        for (int i = 0; i < 32768; i++) mem[i] = 16'(i) ^ 16'h2c5b;
    end
    // addresses 0 and 1 are the accumulators, never served here
    always @(posedge clk_i) begin
        if (ack_o || !mem_i.req) begin
            ack_o <= 1'b0;
            cnt <= 4'h0;
            rdata_o <= ~rdata_o; // released bus inverts the last word each cycle
        end else if (cnt >= lat_i) begin
            ack_o <= 1'b1;
            if (mem_i.wr) mem[mem_i.addr[14:0]] <= mem_i.wdata;
            else rdata_o <= mem[mem_i.addr[14:0]];
        end else cnt <= cnt + 4'h1;
    end
endmodule // ixu_mem_model

// ### dv/ixu_checker.sv
// port assertions for the index unit
`timescale 1ns/1ps
module ixu_checker
    import ixu_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        ce_i,
    input wire logic        req_valid_i,
    input wire ixu_req_t    req_i,
    input wire logic        req_ready_o,
    input wire logic        done_o,
    input wire ixu_mem_t    mem_o,
    input wire logic        mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    input wire ixu_regs_t   regs_o
);
    ixu_req_t    q_ff;
    ixu_regs_t   r_ff;
    logic [15:0] rd_ff;
    wire take = ce_i && req_valid_i && req_ready_o;
    // odd codes of the indexed group use x
    wire [15:0] ix = q_ff.op[0] ? r_ff.x : r_ff.y;
    wire [15:0] ea = (q_ff.opnd + ix) & IXU_ADDR_MASK;
    wire idx = q_ff.op >= IXU_OP_LDA_X && q_ff.op <= IXU_OP_STB_Y
               && !q_ff.ind && !q_ff.code_data_separation_mode;
    always_ff @(posedge clk_i) begin
        if (take) begin
            q_ff <= req_i;
            r_ff <= regs_o;
        end
    end
    always_ff @(posedge clk_i) begin
        if (mem_ack_i && !mem_o.wr) rd_ff <= mem_rdata_i;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_swap_take;
        take && req_i.op inside {IXU_OP_SWP_AX, IXU_OP_SWP_AY,
                                 IXU_OP_SWP_BX, IXU_OP_SWP_BY};
    endsequence
    sequence s_done_soon;
        ##[1:4] done_o;
    endsequence
    a_swap_prompt: assert property (s_swap_take |-> s_done_soon)
        else $error("swap slow");
    a_addr_top_clear: assert property (mem_o.req |-> !mem_o.addr[15])
        else $error("bus address bit 15 set");
    a_acc_not_bus: assert property (mem_o.req |-> mem_o.addr > 16'h0001)
        else $error("accumulator address on bus");
    a_protect_chk: assert property (mem_o.req |-> mem_o.chk)
        else $error("no protect check");
    a_store_a_src: assert property (mem_o.req && mem_o.wr &&
        q_ff.op inside {IXU_OP_STA_X, IXU_OP_STA_Y} |-> mem_o.wdata == r_ff.a)
        else $error("store a data wrong");
    a_store_b_src: assert property (mem_o.req && mem_o.wr &&
        q_ff.op inside {IXU_OP_STB_X, IXU_OP_STB_Y} |-> mem_o.wdata == r_ff.b)
        else $error("store b data wrong");
    a_ea_in_m: assert property (done_o && idx |-> regs_o.m == ea &&
        regs_o.x == r_ff.x && regs_o.y == r_ff.y)
        else $error("m or index wrong");
    a_load_a_word: assert property (done_o &&
        q_ff.op inside {IXU_OP_LDA_X, IXU_OP_LDA_Y} |-> regs_o.a == rd_ff)
        else $error("a not loaded");
    a_jsa_link: assert property (done_o && q_ff.op == IXU_OP_JSA
        |-> regs_o.a == r_ff.p + IXU_PC_STEP2)
        else $error("jump link wrong");
    a_jpy_dest: assert property (done_o && q_ff.op == IXU_OP_JPY
        && !q_ff.code_data_separation_mode |-> regs_o.p == ((q_ff.opnd + r_ff.y) & IXU_ADDR_MASK))
        else $error("indexed jump wrong");
endmodule // ixu_checker

// ### dv/tb_top.sv
// directed tests of the index unit against the memory model
`timescale 1ns/1ps
`define MEM ixu_mem_model_inst.mem
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin \
    errors++; $display("unexpected at %0t: got %h want %h", $time, g, w); \
end end
module tb_top;
    import ixu_pkg::*;
    logic        clk_i, rst_b_i, ce_i, req_valid_i, ld_valid_i;
    logic        req_ready_o, done_o, mem_ack_i;
    logic [15:0] mem_rdata_i;
    logic [3:0]  lat;
    ixu_req_t    req_i;
    ixu_mem_t    mem_o;
    ixu_regs_t   ld_regs_i, regs_o, r0;
    int          errors, num_checks;
    ixu_exec ixu_exec_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .ld_valid_i(ld_valid_i),
        .ld_regs_i(ld_regs_i), .regs_o(regs_o));
    ixu_mem_model ixu_mem_model_inst (.clk_i(clk_i), .mem_i(mem_o),
        .lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    function automatic logic [15:0] ea(input logic [15:0] p, i);
        return (p + i) & IXU_ADDR_MASK; // carry dropped first
    endfunction
    task stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // preload r0, offer one instruction, wait for its done pulse
    task run(input ixu_op_t op, input logic [15:0] opnd,
             input logic ind = 1'b0, input logic code_data_separation_mode = 1'b0,
             input logic [15:0] base = 16'h0000);
        int n;
        @(posedge clk_i) #1;
        ld_valid_i = 1'b1;
        ld_regs_i = r0;
        @(posedge clk_i) #1;
        ld_valid_i = 1'b0;
        req_valid_i = 1'b1;
        req_i = '{op, opnd, ind, code_data_separation_mode, base};
        @(posedge clk_i) #1;
        req_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 60) begin
            @(posedge clk_i) #1;
            n++;
        end
        `CHK(done_o, 1'b1)
    endtask
    task t_indexed;
        logic [15:0] e, w;
        for (int k = 1; k <= 8; k++) begin
            e = ea(16'h0300, k[0] ? r0.x : r0.y); // below and wrapped
            w = `MEM[e[14:0]];
            lat = k[1] ? 4'h3 : 4'h0;
            run(ixu_op_t'(k), 16'h0300);
            `CHK(regs_o.m, e)
            `CHK({regs_o.x, regs_o.y}, {r0.x, r0.y})
            if (k <= 2) `CHK(regs_o.a, w)
            else if (k <= 4) `CHK(regs_o.b, w)
            else `CHK(`MEM[e[14:0]], k <= 6 ? r0.a : r0.b)
            if (k > 4) `CHK(regs_o[95:32], r0[95:32])
        end
        $display("indexed access done");
    endtask
    task t_xy_mem;
        lat = 4'h1;
        run(IXU_OP_LD_X, IXU_ADDR_ACC_B);
        `CHK(regs_o.x, r0.b)
        run(IXU_OP_LD_Y, 16'h0123);
        `CHK(regs_o.y, `MEM[15'h0123])
        run(IXU_OP_ST_Y, IXU_ADDR_ACC_A);
        `CHK({regs_o.a, regs_o.y}, {r0.y, r0.y})
        run(IXU_OP_ST_X, 16'h0456);
        `CHK({`MEM[15'h0456], regs_o.x}, {r0.x, r0.x})
        $display("index load and store done");
    endtask
    task t_swap;
        ixu_regs_t e;
        for (int k = 13; k <= 16; k++) begin
            e = r0;
            case (k)
                13: {e.a, e.x} = {r0.x, r0.a};
                14: {e.a, e.y} = {r0.y, r0.a};
                15: {e.b, e.x} = {r0.x, r0.b};
                default: {e.b, e.y} = {r0.y, r0.b};
            endcase
            run(ixu_op_t'(k), 16'h0000);
            `CHK(regs_o[95:32], e[95:32])
        end
        $display("swap done");
    endtask
    task t_jump;
        run(IXU_OP_JSA, 16'h1234);
        `CHK({regs_o.p, regs_o.a}, {16'h1234, r0.p + IXU_PC_STEP2})
        run(IXU_OP_JSB, 16'h0abc);
        `CHK({regs_o.p, regs_o.b}, {16'h0abc, r0.p + IXU_PC_STEP2})
        run(IXU_OP_JSY, 16'h0600, 1'b1);
        `CHK({regs_o.p, regs_o.y}, {16'h0777, r0.p + IXU_PC_STEP2})
        run(IXU_OP_JPY, 16'h0010, 1'b1);
        `CHK({regs_o.p, regs_o.y}, {ea(16'h0010, r0.y), r0.y})
        $display("jump done");
    endtask
    task t_ind_cds;
        lat = 4'h2;
        run(IXU_OP_LDA_X, 16'h0010, 1'b0, 1'b1, 16'h0200);
        `CHK(regs_o.m, ea(16'h0210, r0.x))
        run(IXU_OP_LDA_X, 16'h0600, 1'b1);
        `CHK({regs_o.m, regs_o.a}, {16'h0775, `MEM[15'h0775]})
        run(IXU_OP_LDB_X, IXU_ADDR_ACC_A, 1'b1);
        `CHK({regs_o.m, regs_o.b}, {16'h110f, `MEM[15'h110f]})
        $display("indirect and base done");
    endtask
    // swap taken, then held two cycles with the enable low
    task t_ce;
        @(posedge clk_i) #1;
        ld_valid_i = 1'b1;
        ld_regs_i = r0;
        @(posedge clk_i) #1;
        ld_valid_i = 1'b0;
        req_valid_i = 1'b1;
        req_i = '{IXU_OP_SWP_AX, 16'h0000, 1'b0, 1'b0, 16'h0000};
        @(posedge clk_i) #1;
        req_valid_i = 1'b0;
        ce_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({done_o, regs_o}, {1'b0, r0})
        ce_i = 1'b1;
        @(posedge clk_i) #1;
        `CHK({done_o, regs_o.a, regs_o.x}, {1'b1, r0.x, r0.a})
        $display("clock enable hold done");
    endtask
    // some twenty instructions of under twenty cycles each, with margin
    initial begin
        #20000;
        errors++;
        stop_test;
    end
    initial begin
        {rst_b_i, req_valid_i, ld_valid_i, lat} = '0;
        ce_i = 1'b1;
        req_i = '0;
        ld_regs_i = '0;
        errors = 0;
        num_checks = 0;
        r0 = '{16'h1111, 16'h2222, 16'hfffe, 16'h8005, 16'h0100, 16'h0};
        repeat (4) @(posedge clk_i);
        #1;
        `CHK({req_ready_o, done_o, mem_o, regs_o}, {2'b10, 131'h0})
        rst_b_i = 1'b1;
        `MEM[15'h0600] = 16'h0777;
        t_indexed;
        t_xy_mem;
        t_swap;
        t_jump;
        t_ind_cds;
        t_ce;
        stop_test;
    end
endmodule // tb_top
bind ixu_exec ixu_checker ixu_checker_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .regs_o(regs_o));
